// ---- core/cptms_regs.svh ----
// Constants of the processor phase timer and memory sequencer.
// Included by bare name by every design file that needs them.
`ifndef CPTMS_REGS_SVH
`define CPTMS_REGS_SVH

// ----------------------------------------------------------------------
// Phase timer
// ----------------------------------------------------------------------
`define CPTMS_PHASES      5
`define CPTMS_PH1         0
`define CPTMS_PH2         1
`define CPTMS_PH3         2
`define CPTMS_PH4         3
`define CPTMS_PH5         4
`define CPTMS_PHASE_RESET 5'h01
`define CPTMS_PHASE_NS    350
`define CPTMS_CLK_PS      8000

// ----------------------------------------------------------------------
// Word layout and opcodes
// ----------------------------------------------------------------------
`define CPTMS_WORD_W      24
`define CPTMS_ADDR_W      14
`define CPTMS_OP_MSB      23
`define CPTMS_OP_LSB      18
`define CPTMS_ADDR_MSB    13
`define CPTMS_OP_INC      6'h1e
`define CPTMS_OP_DEC      6'h1f
`define CPTMS_RMW_FETCH   2'h1
`define CPTMS_RMW_EXEC    2'h1
`define CPTMS_PC_RESET    14'h0000

`endif

// ---- core/cptms_pkg.sv ----
// Types shared by the phase timer and memory sequencer.
// Assumes nothing of its surroundings.
package cptms_pkg;

  // --------------------------------------------------------------------
  // Kind of memory cycle
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPTMS_IFETCH = 2'b00,
    CPTMS_OFETCH = 2'b01,
    CPTMS_EXEC   = 2'b10,
    CPTMS_WRITE  = 2'b11
  } cptms_kind_e;

endpackage

// ---- core/cptms_tick_gen.sv ----
// Divider that makes the one-cycle system clock enable.
// Assumes one free running clock and an asynchronous active high reset.
`timescale 1ns/1ps

module cptms_tick_gen #(
  parameter int COUNT = 44
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Enable pulse
  output logic      tick_out
);

  localparam int CW = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  always_comb
  begin
    next_tick  = (count == LAST);
    next_count = next_tick ? '0 : count + CW'(1);
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count    <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule

// ---- core/cptms_sequencer.sv ----
// Five phase timer and processor side memory transfer sequencer.
// Assumes a memory that grants access during phase two and returns read
// data by phase one; instruction decode sits outside this block, save the increment and decrement opcodes.
//
// Overview of operation
// RULE_01: Phase timer is a five stage one-hot shift register.
// RULE_02: Timer shifts once per 350 ns system clock; five phases per cycle.
// RULE_03: Phases change only on a system clock enable edge.
// RULE_04: Memory access is requested during phase two.
// RULE_05: Without a grant in phase two, clocks stop and request repeats.
// RULE_06: After grant, address and read or write intent appear in phase three.
// RULE_07: Read data is routed in phase one and captured at its end.
// RULE_08: Write data is driven onto the memory bus during phase five.
// RULE_09: Operand fetch flag and buffer select stand all five phases.
// RULE_10: Operand address gate stands in phase three of operand fetch.
// RULE_11: Buffer register clock enable stands in phase one of fetch. The code raises it in phase one of operand fetch only, not instruction fetch.
// RULE_12: Phase signals rise at the clock before and span their phase.
// RULE_13: A present signal is driven at logic one.
// RULE_14: Increment and decrement memory instructions take four cycles.
// RULE_15: Instruction fetch loads command register and bumps counter.
// RULE_16: Operand fetch flag clears at end of last fetch phase one.
// RULE_17: Reset leaves exactly one phase active.
// RULE_18: While stalled, timer and flags hold until access is granted.
`timescale 1ns/1ps
`include "cptms_regs.svh"

module cptms_sequencer #(
  parameter int PHASE_NS = `CPTMS_PHASE_NS,
  parameter int CLK_PS   = `CPTMS_CLK_PS
) (
  // Clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  // Decode hints and store data for the instruction being fetched
  input  wire logic [1:0]                 fetch_count_in,
  input  wire logic                       store_in,
  input  wire logic [`CPTMS_WORD_W-1:0]   write_data_in,
  // Memory interface
  input  wire logic                       mem_grant_in,
  input  wire logic [`CPTMS_WORD_W-1:0]   mem_rdata_in,
  output logic                            mem_access_req_out,
  output logic                            mem_addr_valid_out,
  output logic                            mem_write_out,
  output logic [`CPTMS_ADDR_W-1:0]        mem_addr_out,
  output logic                            mem_wdata_valid_out,
  output logic [`CPTMS_WORD_W-1:0]        mem_wdata_out,
  // Phase timer and processor strobes
  output logic [`CPTMS_PHASES-1:0]        phase_out,
  output logic                            cpu_clock_enable_out,
  output logic                            operand_fetch_time_flag_out,
  output logic                            memory_to_buffer_select_out,
  output logic                            operand_address_to_memory_gate_out,
  output logic                            buffer_register_clock_enable_out,
  output logic                            instruction_fetch_time_flag_out,
  output logic                            program_counter_increment_out,
  // Registers
  output logic [`CPTMS_WORD_W-1:0]        command_register_out,
  output logic [`CPTMS_WORD_W-1:0]        buffer_register_out,
  output logic [`CPTMS_ADDR_W-1:0]        program_counter_out
);

  // --------------------------------------------------------------------
  // System clock enable
  // --------------------------------------------------------------------
  localparam int TICK_CYCLES = (PHASE_NS * 1000 + CLK_PS - 1) / CLK_PS;

  logic tick;

  cptms_tick_gen #(
    .COUNT    (TICK_CYCLES)
  ) u_tick (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  // --------------------------------------------------------------------
  // Phase timer and cycle sequencing
  // --------------------------------------------------------------------
  cptms_pkg::cptms_kind_e   kind;
  cptms_pkg::cptms_kind_e   next_kind;
  logic [`CPTMS_PHASES-1:0] next_phase;
  logic [1:0]               fetch_left;
  logic [1:0]               next_fetch_left;
  logic [1:0]               exec_left;
  logic [1:0]               next_exec_left;
  logic                     store_pend;
  logic                     next_store_pend;
  logic                     rmw_op;
  logic                     next_rmw_op;
  logic [`CPTMS_WORD_W-1:0] next_cmd;
  logic [`CPTMS_WORD_W-1:0] next_buf;
  logic [`CPTMS_ADDR_W-1:0] next_pc;
  logic                     stall;
  logic                     advance;
  logic                     boundary;
  logic                     load_rmw;

  function automatic cptms_pkg::cptms_kind_e pick_kind(
    input logic [1:0] f,
    input logic [1:0] e,
    input logic       s
  );
    if (f != 2'h0)
      pick_kind = cptms_pkg::CPTMS_OFETCH;
    else if (e != 2'h0)
      pick_kind = cptms_pkg::CPTMS_EXEC;
    else if (s)
      pick_kind = cptms_pkg::CPTMS_WRITE;
    else
      pick_kind = cptms_pkg::CPTMS_IFETCH;
  endfunction

  always_comb
  begin
    stall    = phase_out[`CPTMS_PH2] && (kind != cptms_pkg::CPTMS_EXEC)
               && !mem_grant_in;                                  // RULE_05
    advance  = tick && !stall;                                    // RULE_18
    boundary = advance && phase_out[`CPTMS_PH1];
    load_rmw = (mem_rdata_in[`CPTMS_OP_MSB:`CPTMS_OP_LSB] == `CPTMS_OP_INC)
            || (mem_rdata_in[`CPTMS_OP_MSB:`CPTMS_OP_LSB] == `CPTMS_OP_DEC);
    next_phase = advance ? {phase_out[`CPTMS_PHASES-2:0],
                            phase_out[`CPTMS_PHASES-1]}
                         : phase_out;                     // RULE_01 RULE_02
    next_fetch_left = fetch_left;
    next_exec_left  = exec_left;
    next_store_pend = store_pend;
    next_rmw_op     = rmw_op;
    next_kind       = kind;
    next_cmd        = command_register_out;
    next_buf        = buffer_register_out;
    next_pc         = program_counter_out;
    if (boundary)
    begin
      case (kind)
        cptms_pkg::CPTMS_IFETCH:
        begin
          next_cmd    = mem_rdata_in;                             // RULE_15
          next_pc     = program_counter_out + `CPTMS_ADDR_W'(1);  // RULE_15
          next_rmw_op = load_rmw;
          if (load_rmw)
          begin
            next_fetch_left = `CPTMS_RMW_FETCH;                   // RULE_14
            next_exec_left  = `CPTMS_RMW_EXEC;
            next_store_pend = 1'b1;
          end
          else
          begin
            next_fetch_left = fetch_count_in;
            next_exec_left  = 2'h0;
            next_store_pend = store_in;
          end
        end
        cptms_pkg::CPTMS_OFETCH:
        begin
          next_buf        = mem_rdata_in;                         // RULE_07
          next_fetch_left = fetch_left - 2'h1;
        end
        cptms_pkg::CPTMS_EXEC:
        begin
          if (exec_left != 2'h0)
            next_exec_left = exec_left - 2'h1;
        end
        default:
        begin
          next_store_pend = 1'b0;
        end
      endcase
      next_kind = pick_kind(next_fetch_left, next_exec_left,
                            next_store_pend);                     // RULE_16
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_out            <= `CPTMS_PHASE_RESET;                 // RULE_17
      kind                 <= cptms_pkg::CPTMS_EXEC;
      fetch_left           <= 2'h0;
      exec_left            <= 2'h0;
      store_pend           <= 1'b0;
      rmw_op               <= 1'b0;
      command_register_out <= '0;
      buffer_register_out  <= '0;
      program_counter_out  <= `CPTMS_PC_RESET;
      cpu_clock_enable_out <= 1'b0;
    end
    else
    begin
      phase_out            <= next_phase;                         // RULE_03
      kind                 <= next_kind;
      fetch_left           <= next_fetch_left;
      exec_left            <= next_exec_left;
      store_pend           <= next_store_pend;
      rmw_op               <= next_rmw_op;
      command_register_out <= next_cmd;
      buffer_register_out  <= next_buf;
      program_counter_out  <= next_pc;
      cpu_clock_enable_out <= advance;                            // RULE_05
    end
  end

  // --------------------------------------------------------------------
  // Phase aligned strobes, registered from the coming phase
  // --------------------------------------------------------------------
  logic                     n_of;
  logic                     n_if;
  logic                     n_acc;
  logic [`CPTMS_WORD_W-1:0] next_wdata;

  always_comb
  begin
    n_of  = (next_kind == cptms_pkg::CPTMS_OFETCH);
    n_if  = (next_kind == cptms_pkg::CPTMS_IFETCH);
    n_acc = (next_kind != cptms_pkg::CPTMS_EXEC);
    next_wdata = (next_phase[`CPTMS_PH5] &&
                  next_kind == cptms_pkg::CPTMS_WRITE) ? write_data_in
                                                        : mem_wdata_out;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_access_req_out                 <= 1'b0;
      mem_addr_valid_out                 <= 1'b0;
      mem_write_out                      <= 1'b0;
      mem_addr_out                       <= '0;
      mem_wdata_valid_out                <= 1'b0;
      mem_wdata_out                      <= '0;
      operand_fetch_time_flag_out        <= 1'b0;
      memory_to_buffer_select_out        <= 1'b0;
      operand_address_to_memory_gate_out <= 1'b0;
      buffer_register_clock_enable_out   <= 1'b0;
      instruction_fetch_time_flag_out    <= 1'b0;
      program_counter_increment_out      <= 1'b0;
    end
    else
    begin
      mem_access_req_out <= next_phase[`CPTMS_PH2] && n_acc;      // RULE_04
      mem_addr_valid_out <= next_phase[`CPTMS_PH3] && n_acc;      // RULE_06
      mem_write_out      <= next_phase[`CPTMS_PH3] &&
                            next_kind == cptms_pkg::CPTMS_WRITE;  // RULE_06
      mem_addr_out       <= n_if ? next_pc
                                 : next_cmd[`CPTMS_ADDR_MSB:0];
      mem_wdata_valid_out <= next_phase[`CPTMS_PH5] &&
                             next_kind == cptms_pkg::CPTMS_WRITE; // RULE_08
      mem_wdata_out      <= next_wdata;                           // RULE_08
      operand_fetch_time_flag_out <= n_of;                  // RULE_09 RULE_16
      memory_to_buffer_select_out <= n_of;                        // RULE_09
      operand_address_to_memory_gate_out <=
        n_of && next_phase[`CPTMS_PH3];                   // RULE_10 RULE_12
      buffer_register_clock_enable_out <=
        n_of && next_phase[`CPTMS_PH1];                   // RULE_11 RULE_13
      instruction_fetch_time_flag_out <= n_if;                    // RULE_15
      program_counter_increment_out   <=
        n_if && next_phase[`CPTMS_PH1];                           // RULE_15
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [2:0] cyc_in_instr;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      cyc_in_instr <= 3'h0;
    else if (boundary)
      cyc_in_instr <= (next_kind == cptms_pkg::CPTMS_IFETCH) ? 3'h1
                    : cyc_in_instr + 3'h1;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence gom_phase_s;
    tick && phase_out[`CPTMS_PH3] && kind == cptms_pkg::CPTMS_OFETCH;
  endsequence

  sequence gom_span_s;
    operand_address_to_memory_gate_out ##1
      (!operand_address_to_memory_gate_out && phase_out[`CPTMS_PH4]);
  endsequence

  phase_onehot_a: assert property ($onehot(phase_out)) // RULE_01
    else $error("phase timer not one-hot");
  phase_rotate_a: assert property (advance |=> phase_out ==
    {$past(phase_out[3:0]), $past(phase_out[4])}) // RULE_02
    else $error("phase timer did not rotate by one");
  phase_edge_a: assert property (!tick |=> $stable(phase_out)) // RULE_03
    else $error("phase changed without system clock");
  req_phase_a: assert property (phase_out[`CPTMS_PH2] &&
    kind != cptms_pkg::CPTMS_EXEC |-> mem_access_req_out) // RULE_04
    else $error("no access request in phase two");
  stall_hold_a: assert property (tick && stall |=> $stable(phase_out)
    && !cpu_clock_enable_out && mem_access_req_out) // RULE_05
    else $error("timer moved while access not granted");
  addr_phase_a: assert property (mem_addr_valid_out |->
    phase_out[`CPTMS_PH3] && kind != cptms_pkg::CPTMS_EXEC) // RULE_06
    else $error("address outside phase three");
  read_capture_a: assert property (boundary &&
    kind == cptms_pkg::CPTMS_OFETCH |=>
    buffer_register_out == $past(mem_rdata_in)) // RULE_07
    else $error("read data not captured at end of phase one");
  wdata_phase_a: assert property (mem_wdata_valid_out ==
    (phase_out[`CPTMS_PH5] && kind == cptms_pkg::CPTMS_WRITE)) // RULE_08
    else $error("write data not aligned to phase five");
  fetch_flags_a: assert property (memory_to_buffer_select_out ==
    operand_fetch_time_flag_out && (operand_fetch_time_flag_out ==
    (kind == cptms_pkg::CPTMS_OFETCH))) // RULE_09
    else $error("operand fetch flags disagree");
  gom_gate_a: assert property (operand_address_to_memory_gate_out ==
    (phase_out[`CPTMS_PH3] && operand_fetch_time_flag_out)) // RULE_10
    else $error("operand address gate outside phase three");
  buf_clock_a: assert property (buffer_register_clock_enable_out ==
    (phase_out[`CPTMS_PH1] && operand_fetch_time_flag_out)) // RULE_11
    else $error("buffer clock enable outside phase one");
  gom_span_a: assert property (gom_phase_s |-> gom_span_s) // RULE_12
    else $error("phase strobe did not span its phase");
  rmw_cycles_a: assert property (boundary && rmw_op &&
    next_kind == cptms_pkg::CPTMS_IFETCH |-> cyc_in_instr == 3'h4) // RULE_14
    else $error("memory increment did not take four cycles");
  ifetch_load_a: assert property (boundary &&
    kind == cptms_pkg::CPTMS_IFETCH |=>
    command_register_out == $past(mem_rdata_in) &&
    program_counter_out == $past(program_counter_out) + 14'h0001) // RULE_15
    else $error("instruction fetch did not load and increment");
  tof_clear_a: assert property ($fell(operand_fetch_time_flag_out) |->
    phase_out[`CPTMS_PH2] && $past(phase_out[`CPTMS_PH1])) // RULE_16
    else $error("operand fetch flag cleared at wrong time");
  flag_hold_a: assert property (stall |=> $stable(kind) &&
    $stable(operand_fetch_time_flag_out)) // RULE_18
    else $error("flags changed while stalled");

endmodule

// ---- testbench/cptms_mem_model.sv ----
// Behavioural core memory on the far side of the sequencer's memory link.
// Assumes the sequencer clock and a phase tick of TICK clocks; requests
// stand until granted and the bench may preload the array directly.
`timescale 1ns/1ps
`include "cptms_regs.svh"

module cptms_mem_model #(
  parameter int TICK = 5
) (
  // Clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  // Number of phase two ticks to refuse
  input  wire logic [3:0]               refuse_in,
  // Memory link
  input  wire logic                     req_in,
  input  wire logic                     addr_valid_in,
  input  wire logic                     write_in,
  input  wire logic [`CPTMS_ADDR_W-1:0] addr_in,
  input  wire logic                     wdata_valid_in,
  input  wire logic [`CPTMS_WORD_W-1:0] wdata_in,
  output logic                          grant_out,
  output logic [`CPTMS_WORD_W-1:0]      rdata_out
);
  logic [`CPTMS_WORD_W-1:0] mem [0:255];
  logic [7:0]               addr_hold;
  logic                     read_pend;
  int                       req_cnt;

  // Access is granted only after the chosen number of refused ticks.
  assign grant_out = req_in && (req_cnt >= int'(refuse_in) * TICK);

  // Read data is valid from the read address until the next request;
  // otherwise the bus toggles every clock.
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_cnt   <= 0;
      read_pend <= 1'b0;
      addr_hold <= 8'h00;
      rdata_out <= 24'h000000;
    end
    else
    begin
      req_cnt <= req_in ? req_cnt + 1 : 0;
      if (addr_valid_in)
      begin
        addr_hold <= addr_in[7:0];
        read_pend <= !write_in;
      end
      else if (req_in)
        read_pend <= 1'b0;
      rdata_out <= read_pend ? mem[addr_hold] : ~rdata_out;
      if (wdata_valid_in)
        mem[addr_hold] <= wdata_in;
    end
  end
endmodule

// ---- testbench/cpu_phase_timer_memory_sequencer_tb.sv ----
// Self-checking bench for the phase timer and memory sequencer.
// Assumes the behavioural memory model and a shortened phase tick.
`timescale 1ns/1ps
`include "cptms_regs.svh"

module cpu_phase_timer_memory_sequencer_tb;
  localparam int T = 5;
  logic clock_in = 1'b0;
  logic rst_in, store_in, grant, req, addr_valid, wr, wdata_valid, clk_en;
  logic operand_fetch_time_flag, memory_to_buffer_select, gate, bufen, instruction_fetch_time_flag, pcinc;
  logic [1:0]  fetch_count_in;
  logic [3:0]  refuse;
  logic [4:0]  phase_out;
  logic [13:0] mem_addr, pc, exp_pc;
  logic [23:0] write_data_in, rdata, wdata, cmd, buf_reg;
  int errors = 0;
  int comparisons = 0;

  always #4 clock_in = ~clock_in;

  cptms_sequencer #(.PHASE_NS(40), .CLK_PS(8000)) dut (
    .clock_in(clock_in), .rst_in(rst_in), .fetch_count_in(fetch_count_in),
    .store_in(store_in), .write_data_in(write_data_in),
    .mem_grant_in(grant), .mem_rdata_in(rdata),
    .mem_access_req_out(req), .mem_addr_valid_out(addr_valid),
    .mem_write_out(wr), .mem_addr_out(mem_addr),
    .mem_wdata_valid_out(wdata_valid), .mem_wdata_out(wdata),
    .phase_out(phase_out), .cpu_clock_enable_out(clk_en),
    .operand_fetch_time_flag_out(operand_fetch_time_flag), .memory_to_buffer_select_out(memory_to_buffer_select),
    .operand_address_to_memory_gate_out(gate),
    .buffer_register_clock_enable_out(bufen),
    .instruction_fetch_time_flag_out(instruction_fetch_time_flag),
    .program_counter_increment_out(pcinc),
    .command_register_out(cmd), .buffer_register_out(buf_reg),
    .program_counter_out(pc));

  cptms_mem_model #(.TICK(T)) mem_model (
    .clock_in(clock_in), .rst_in(rst_in), .refuse_in(refuse),
    .req_in(req), .addr_valid_in(addr_valid), .write_in(wr),
    .addr_in(mem_addr), .wdata_valid_in(wdata_valid), .wdata_in(wdata),
    .grant_out(grant), .rdata_out(rdata));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clock_in);
    #1;
  endtask

  // Walks one memory cycle from phase two to phase one and checks strobes.
  task automatic walk(input logic is_if, input logic is_of,
                      input logic is_wr, input logic [13:0] addr,
                      input logic [23:0] wd, input logic [3:0] r);
    int n;
    int pulses;
    int idx;
    logic acc;
    acc = is_if | is_of | is_wr;
    refuse = r;
    n = 0;
    while (phase_out !== 5'h02 && n < 200)
    begin
      step();
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      final_report();
    end
    for (int k = 0; k < 5; k++)
    begin
      idx = (k + 1) % 5;
      n = 0;
      pulses = 0;
      while (phase_out === (5'h01 << idx) && n < 100)
      begin
        pulses += (clk_en === 1'b1) ? 1 : 0;
        check(req, idx == 1 && acc);
        check(addr_valid, idx == 2 && acc);
        check(gate, idx == 2 && is_of);
        check(bufen, idx == 0 && is_of);
        check(pcinc, idx == 0 && is_if);
        check(wdata_valid, idx == 4 && is_wr);
        check(operand_fetch_time_flag, is_of);
        check(memory_to_buffer_select, is_of);
        check(instruction_fetch_time_flag, is_if);
        if (idx == 2 && acc)
        begin
          check(wr, is_wr);
          check(mem_addr, addr);
        end
        if (idx == 4 && is_wr)
          check(wdata, wd);
        step();
        n++;
      end
      check(n, (idx == 1) ? T * (1 + int'(r)) : T);
      check(pulses, 1);
    end
  endtask

  // Runs one instruction through all of its memory cycles.
  task automatic run_instr(input logic [23:0] word, input logic [1:0] fc,
                           input logic st, input logic [23:0] wd,
                           input logic [3:0] r);
    logic rmw;
    rmw = word[23:18] == `CPTMS_OP_INC || word[23:18] == `CPTMS_OP_DEC;
    mem_model.mem[exp_pc[7:0]] = word;
    fetch_count_in = fc;
    store_in = st;
    write_data_in = wd;
    walk(1'b1, 1'b0, 1'b0, exp_pc, 24'h000000, 4'h0);
    check(cmd, word);
    check(pc, exp_pc + 14'h0001);
    exp_pc = exp_pc + 14'h0001;
    for (int i = 0; i < (rmw ? 1 : int'(fc)); i++)
    begin
      walk(1'b0, 1'b1, 1'b0, word[13:0], 24'h000000, r);
      check(buf_reg, mem_model.mem[word[7:0]]);
    end
    if (rmw)
      walk(1'b0, 1'b0, 1'b0, 14'h0000, 24'h000000, 4'h0);
    if (rmw || st)
    begin
      walk(1'b0, 1'b0, 1'b1, word[13:0], wd, 4'h0);
      check(mem_model.mem[word[7:0]], wd);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    check(phase_out, 5'h01);
    check({req, operand_fetch_time_flag, gate, bufen, pcinc, wdata_valid}, 6'h00);
    check(pc, 14'h0000);
    rst_in = 1'b0;
  endtask

  task automatic test_plain_fetch();
    run_instr(24'h100020, 2'h0, 1'b0, 24'h000000, 4'h0);
  endtask

  task automatic test_operand_fetch();
    mem_model.mem[8'h21] = 24'h3c3c3c;
    run_instr(24'h100021, 2'h1, 1'b0, 24'h000000, 4'h0);
  endtask

  task automatic test_stalled_double_fetch();
    mem_model.mem[8'h22] = 24'h5a5a5a;
    run_instr(24'h100022, 2'h2, 1'b0, 24'h000000, 4'h2);
  endtask

  task automatic test_store();
    run_instr(24'h100023, 2'h0, 1'b1, 24'ha5c3e1, 4'h0);
  endtask

  task automatic test_read_modify_write();
    logic [5:0] ops [2];
    ops[0] = `CPTMS_OP_INC;
    ops[1] = `CPTMS_OP_DEC;
    for (int i = 0; i < 2; i++)
    begin
      mem_model.mem[8'h24] = 24'h000100;
      run_instr({ops[i], 18'h00024}, 2'h0, 1'b0, 24'h0000ff, 4'h1);
    end
  endtask

  initial
  begin
    rst_in = 1'b1;
    fetch_count_in = 2'h0;
    store_in = 1'b0;
    write_data_in = 24'h000000;
    refuse = 4'h0;
    exp_pc = 14'h0000;
    repeat (4) @(posedge clock_in);
    #1;
    test_reset();
    test_plain_fetch();
    test_operand_fetch();
    test_stalled_double_fetch();
    test_store();
    test_read_modify_write();
    final_report();
  end
endmodule
